// ### sbw_pkg.sv
package sbw_pkg;

   // ----------------------------------------------------------------
   // Word and command layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int ADDR_W_DEF = 6;
   localparam int LEAD_W = 4;
   localparam logic [1:0] OP_EXT = 2'h0;
   localparam logic [1:0] EXT_LOCK = 2'h0;
   localparam logic [1:0] EXT_FILL = 2'h1;
   localparam logic [1:0] EXT_CLEAR = 2'h2;
   localparam logic [1:0] EXT_UNLOCK = 2'h3;
   localparam logic [15:0] CLEAR_WORD = 16'hffff;
   localparam logic START_BIT = 1'b1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_MHZ = 40;
   localparam int T_PR_US = 8000;
   localparam int PROG_CYCLES_DEF = T_PR_US * SYS_MHZ;
   localparam int SK_HALF_DEF = 10;
   localparam int CS_GAP_DEF = 20;

   typedef enum logic [1:0] {
      SBW_FILL,
      SBW_CLEAR,
      SBW_UNLOCK,
      SBW_LOCK
   } sbw_cmd_type;

endpackage : sbw_pkg

// ### sbw_link_if.sv
`timescale 1ns/1ps
interface sbw_link_if;
   logic chip_sel;
   logic serial_clk;
   logic serial_in;
   logic out_d;
   logic out_oe_n;
   wire serial_out;

   // The floating output is modelled as a weak pull-down, so a host reads low
   // whenever the device is not driving.
   assign serial_out = ~out_oe_n & out_d;

   modport device (
      input chip_sel,
      input serial_clk,
      input serial_in,
      output out_d,
      output out_oe_n
   );

   modport host (
      output chip_sel,
      output serial_clk,
      output serial_in,
      input serial_out
   );
endinterface : sbw_link_if

// ### sbw_eeprom_dev.sv
`timescale 1ns/1ps
module sbw_eeprom_dev #(
   parameter int ADDR_W = sbw_pkg::ADDR_W_DEF,
   parameter int PROG_CYCLES = sbw_pkg::PROG_CYCLES_DEF
) (
   // System clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Supply monitor
   input wire logic low_supply_i,
   // Array inspection
   input wire logic [ADDR_W-1:0] peek_addr_i,
   output logic [sbw_pkg::DATA_W-1:0] peek_data_o,
   // State
   output logic prog_en_o,
   output logic busy_o,
   // Serial link
   sbw_link_if.device link
);

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   // parameterised command layout
   localparam int DEPTH = 1 << ADDR_W;
   localparam int HDR_N = 2 + ADDR_W;
   localparam int FULL_N = HDR_N + sbw_pkg::DATA_W;
   localparam int CNT_W = $clog2(FULL_N + 2);
   localparam logic [CNT_W-1:0] CNT_HDR = CNT_W'(HDR_N);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FULL_N);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FULL_N + 1);
   localparam logic [CNT_W-1:0] CNT_LEAD = CNT_W'(sbw_pkg::LEAD_W);
   localparam int PT_W = $clog2(PROG_CYCLES + 1);
   localparam logic [PT_W-1:0] PT_LAST = PT_W'(PROG_CYCLES - 1);

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   logic frame_rst;
   logic started;
   logic take_start;
   logic busy_lm;
   logic busy_l;
   logic [CNT_W-1:0] cnt;
   logic [sbw_pkg::LEAD_W-1:0] lead;
   logic [sbw_pkg::DATA_W-1:0] data_sh;
   logic start_tgl;

   // The frame's own chip select ends it, since the serial clock stops with it.
   assign frame_rst = reset_i | ~link.chip_sel;

   assign take_start = ~started & ~busy_l & link.serial_in;

   always_ff @(posedge link.serial_clk or posedge reset_i) begin
      if (reset_i) begin
         busy_lm <= 1'b0;
         busy_l <= 1'b0;
      end else begin
         busy_lm <= busy_o;
         busy_l <= busy_lm;
      end
   end

   always_ff @(posedge link.serial_clk or posedge frame_rst) begin
      if (frame_rst) begin
         started <= 1'b0;
      end else if (take_start) begin
         started <= 1'b1;
      end
   end

   // These hold their value after chip select falls, so the system side can
   // read them while the serial clock stands still.
   // count clocks after start
   always_ff @(posedge link.serial_clk or posedge reset_i) begin
      if (reset_i) begin
         cnt <= '0;
         lead <= '0;
         data_sh <= '0;
         start_tgl <= 1'b0;
      end else if (take_start) begin
         cnt <= '0;
         start_tgl <= ~start_tgl;
      end else if (started) begin
         if (cnt != CNT_MAX) begin
            cnt <= cnt + 1'b1;
         end
         if (cnt < CNT_LEAD) begin
            lead <= {lead[sbw_pkg::LEAD_W-2:0], link.serial_in};
         end
         data_sh <= {data_sh[sbw_pkg::DATA_W-2:0], link.serial_in};
      end
   end

   // ----------------------------------------------------------------
   // Crossing into the system domain
   // ----------------------------------------------------------------
   logic cs_m;
   logic cs_s;
   logic cs_q;
   logic tgl_m;
   logic tgl_s;
   logic low_m;
   logic low_s;
   logic seen_tgl;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cs_m <= 1'b0;
         cs_s <= 1'b0;
         cs_q <= 1'b0;
         tgl_m <= 1'b0;
         tgl_s <= 1'b0;
         low_m <= 1'b1;
         low_s <= 1'b1;
      end else begin
         cs_m <= link.chip_sel;
         cs_s <= cs_m;
         cs_q <= cs_s;
         tgl_m <= start_tgl;
         tgl_s <= tgl_m;
         low_m <= low_supply_i;
         low_s <= low_m;
      end
   end

   // ----------------------------------------------------------------
   // Command decode at the end of a frame
   // ----------------------------------------------------------------
   // The counters and shift registers are sampled only after chip select has
   // been seen low through the synchroniser, so they are already stable.
   logic cs_fall;
   logic new_frame;
   logic is_ext;
   logic [1:0] ext;
   logic take_cmd;
   logic fire_fill;
   logic fire_clear;
   logic do_unlock;
   logic do_lock;
   logic prog_en;
   logic busy;

   assign cs_fall = cs_q & ~cs_s;
   assign new_frame = tgl_s != seen_tgl;
   assign is_ext = lead[3:2] == sbw_pkg::OP_EXT;
   assign ext = lead[1:0];
   assign take_cmd = cs_fall & new_frame & ~busy & is_ext;

   assign fire_fill = take_cmd & (ext == sbw_pkg::EXT_FILL) & (cnt == CNT_FULL) & prog_en & ~low_s;
   assign fire_clear = take_cmd & (ext == sbw_pkg::EXT_CLEAR) & (cnt == CNT_HDR) & prog_en & ~low_s;
   assign do_unlock = take_cmd & (ext == sbw_pkg::EXT_UNLOCK) & (cnt >= CNT_LEAD) & (cnt <= CNT_HDR);
   assign do_lock = take_cmd & (ext == sbw_pkg::EXT_LOCK) & (cnt >= CNT_LEAD) & (cnt <= CNT_HDR);

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         seen_tgl <= 1'b0;
      end else if (cs_fall) begin
         seen_tgl <= tgl_s;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prog_en <= 1'b0;
      end else if (low_s) begin
         prog_en <= 1'b0;
      end else if (do_unlock) begin
         prog_en <= 1'b1;
      end else if (do_lock) begin
         prog_en <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Programming sequence
   // ----------------------------------------------------------------
   logic [PT_W-1:0] timer;
   logic [ADDR_W:0] widx;
   logic [sbw_pkg::DATA_W-1:0] pdata;
   logic [sbw_pkg::DATA_W-1:0] mem [DEPTH];

   // A supply drop aborts the sequence; words already written stay as they are.
   // fill uses shifted word
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy <= 1'b0;
         timer <= '0;
         widx <= '0;
         pdata <= '0;
      end else if (fire_fill | fire_clear) begin
         busy <= 1'b1;
         timer <= '0;
         widx <= '0;
         pdata <= fire_fill ? data_sh : sbw_pkg::CLEAR_WORD;
      end else if (busy) begin
         timer <= timer + 1'b1;
         if (!widx[ADDR_W]) begin
            widx <= widx + 1'b1;
         end
         if (low_s || timer == PT_LAST) begin
            busy <= 1'b0;
         end
      end
   end

   // One word per system clock; the programming time must be at least the depth.
   // every location written
   always_ff @(posedge sys_clk_i) begin
      if (busy && !low_s && !widx[ADDR_W]) begin
         mem[widx[ADDR_W-1:0]] <= pdata;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         peek_data_o <= '0;
      end else begin
         peek_data_o <= mem[peek_addr_i];
      end
   end

   // ----------------------------------------------------------------
   // Status output
   // ----------------------------------------------------------------
   logic status;

   // Status stays available across verify frames until a new start bit arrives.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         status <= 1'b0;
      end else if (fire_fill | fire_clear) begin
         status <= 1'b1;
      end else if (new_frame) begin
         status <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         link.out_d <= 1'b0;
         link.out_oe_n <= 1'b1;
         prog_en_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         link.out_d <= ~busy;
         link.out_oe_n <= ~(cs_s & status);
         prog_en_o <= prog_en;
         busy_o <= busy;
      end
   end

endmodule : sbw_eeprom_dev

// ### sbw_eeprom_host.sv
`timescale 1ns/1ps
module sbw_eeprom_host #(
   parameter int ADDR_W = sbw_pkg::ADDR_W_DEF,
   parameter int SK_HALF = sbw_pkg::SK_HALF_DEF,
   parameter int CS_GAP = sbw_pkg::CS_GAP_DEF
) (
   // System clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Command request
   input wire logic cmd_valid_i,
   input wire sbw_pkg::sbw_cmd_type cmd_kind_i,
   input wire logic [sbw_pkg::DATA_W-1:0] cmd_data_i,
   output logic cmd_ready_o,
   output logic done_o,
   // Serial link
   sbw_link_if.host link
);

   // ----------------------------------------------------------------
   // Sizes and state
   // ----------------------------------------------------------------
   localparam int HDR_N = 2 + ADDR_W;
   localparam int FR_W = 1 + HDR_N + sbw_pkg::DATA_W;
   localparam int LEFT_W = $clog2(FR_W + 1);
   localparam logic [15:0] PH_SK = 16'(SK_HALF - 1);
   localparam logic [15:0] PH_GAP = 16'(CS_GAP - 1);

   typedef enum logic [1:0] {
      H_IDLE,
      H_SEND,
      H_GAP,
      H_POLL
   } sbw_hstate_type;

   sbw_hstate_type state;
   logic [FR_W-1:0] frame;
   logic [LEFT_W-1:0] left;
   logic [15:0] ph;
   logic want_poll;
   logic cs;
   logic sk;
   logic si;
   logic so_m;
   logic so_s;
   logic [1:0] ext;

   assign link.chip_sel = cs;
   assign link.serial_clk = sk;
   assign link.serial_in = si;

   always_comb begin
      case (cmd_kind_i)
         sbw_pkg::SBW_FILL: ext = sbw_pkg::EXT_FILL;
         sbw_pkg::SBW_CLEAR: ext = sbw_pkg::EXT_CLEAR;
         sbw_pkg::SBW_UNLOCK: ext = sbw_pkg::EXT_UNLOCK;
         default: ext = sbw_pkg::EXT_LOCK;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         so_m <= 1'b0;
         so_s <= 1'b0;
      end else begin
         so_m <= link.serial_out;
         so_s <= so_m;
      end
   end

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   // Chip select is held low while idle so the device can never be mid-frame
   // when this end is reset or stopped.
   // chip select idles low
   // frame ends with chip select low
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= H_IDLE;
         frame <= '0;
         left <= '0;
         ph <= '0;
         want_poll <= 1'b0;
         cs <= 1'b0;
         sk <= 1'b0;
         si <= 1'b0;
         cmd_ready_o <= 1'b1;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (state)
            H_IDLE: begin
               if (cmd_valid_i) begin
                  frame <= {sbw_pkg::START_BIT, sbw_pkg::OP_EXT, ext, (ADDR_W - 2)'(0), cmd_data_i};
                  left <= (cmd_kind_i == sbw_pkg::SBW_FILL) ? LEFT_W'(FR_W) : LEFT_W'(1 + HDR_N);
                  want_poll <= (cmd_kind_i == sbw_pkg::SBW_FILL) | (cmd_kind_i == sbw_pkg::SBW_CLEAR);
                  si <= sbw_pkg::START_BIT;
                  cs <= 1'b1;
                  ph <= '0;
                  cmd_ready_o <= 1'b0;
                  state <= H_SEND;
               end
            end
            H_SEND: begin
               if (ph != PH_SK) begin
                  ph <= ph + 1'b1;
               end else begin
                  ph <= '0;
                  sk <= ~sk;
                  if (sk) begin
                     frame <= {frame[FR_W-2:0], 1'b0};
                     left <= left - 1'b1;
                     si <= frame[FR_W-2];
                     if (left == LEFT_W'(1)) begin
                        cs <= 1'b0;
                        si <= 1'b0;
                        state <= H_GAP;
                     end
                  end
               end
            end
            H_GAP: begin
               if (ph != PH_GAP) begin
                  ph <= ph + 1'b1;
               end else begin
                  ph <= '0;
                  if (want_poll) begin
                     cs <= 1'b1;
                     state <= H_POLL;
                  end else begin
                     done_o <= 1'b1;
                     cmd_ready_o <= 1'b1;
                     state <= H_IDLE;
                  end
               end
            end
            H_POLL: begin
               if (so_s) begin
                  cs <= 1'b0;
                  want_poll <= 1'b0;
                  state <= H_GAP;
               end
            end
            default: begin
               state <= H_IDLE;
               cs <= 1'b0;
            end
         endcase
      end
   end

endmodule : sbw_eeprom_host

// ### sbw_link_props.sv
`timescale 1ns/1ps
module sbw_link_props #(
   parameter int PROG_CYCLES = 200
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Device state
   input wire logic low_supply_i,
   input wire logic prog_en_o,
   input wire logic busy_o,
   // Link
   input wire logic chip_sel,
   input wire logic serial_clk,
   input wire logic out_d,
   input wire logic out_oe_n
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   // ------------------
   // Helper counters
   // ------------------
   int busy_len;
   int cs_low_len;
   logic ls_seen;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_len <= 0;
      end else begin
         busy_len <= busy_o ? busy_len + 1 : 0;
      end
   end

   // Saturates so that a long idle spell cannot wrap round.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cs_low_len <= 0;
      end else begin
         cs_low_len <= chip_sel ? 0 : (cs_low_len < 255 ? cs_low_len + 1 : cs_low_len);
      end
   end

   // A supply dip aborts programming early, so its length is not checked then.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ls_seen <= 1'h0;
      end else begin
         ls_seen <= busy_o & (ls_seen | low_supply_i);
      end
   end

   // ------------------
   // Properties
   // ------------------
   sequence s_busy_shown;
      busy_o ##1 (busy_o && !out_oe_n);
   endsequence

   sequence s_ready_shown;
      !busy_o ##1 (!busy_o && !out_oe_n);
   endsequence

   a_float_when_idle: assert property (!chip_sel [*5] |-> out_oe_n)
      else $error("serial output driven while chip select low");
   a_busy_shows_low: assert property (s_busy_shown |-> !out_d)
      else $error("status high while programming");
   a_ready_shows_high: assert property (s_ready_shown |-> out_d)
      else $error("status low while idle");
   a_busy_exact_len: assert property ($fell(busy_o) && !ls_seen |-> busy_len == PROG_CYCLES)
      else $error("programming period length wrong");
   a_write_after_cs: assert property ($rose(busy_o) |-> cs_low_len inside {[2:8]})
      else $error("write began without a chip select fall");
   a_write_enabled: assert property ($rose(busy_o) |-> prog_en_o)
      else $error("write began while programming disabled");
   a_enable_at_cs: assert property ($rose(prog_en_o) |-> cs_low_len inside {[2:8]})
      else $error("enable changed without a chip select fall");
   a_supply_locks: assert property (low_supply_i [*5] |-> !prog_en_o && !busy_o)
      else $error("low supply did not force lock");
   a_clock_idle: assert property (!chip_sel |-> !serial_clk)
      else $error("serial clock runs while deselected");
endmodule : sbw_link_props

// ### serial_eeprom_bulk_write_guard_bench.sv
`timescale 1ns/1ps
module serial_eeprom_bulk_write_guard_bench;
   localparam int PC = 200;
   localparam int AW = sbw_pkg::ADDR_W_DEF;
   logic sys_clk_i;
   logic reset_i;
   logic low_supply;
   logic cmd_valid;
   sbw_pkg::sbw_cmd_type cmd_kind;
   logic [15:0] cmd_data;
   logic done;
   logic ready;
   logic [AW-1:0] peek_addr;
   logic [15:0] peek_data [2];
   logic prog_en [2];
   logic busy [2];
   logic [31:0] rs;
   int n_errors;
   int checks;
   int men [2];
   int mm [2][64];
   sbw_link_if link ();
   sbw_link_if link2 ();

   sbw_eeprom_host sbw_eeprom_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid),
      .cmd_kind_i(cmd_kind), .cmd_data_i(cmd_data), .cmd_ready_o(ready), .done_o(done), .link(link.host));
   sbw_eeprom_dev #(.PROG_CYCLES(PC)) sbw_eeprom_dev_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .low_supply_i(low_supply), .peek_addr_i(peek_addr), .peek_data_o(peek_data[0]), .prog_en_o(prog_en[0]),
      .busy_o(busy[0]), .link(link.device));
   // The second device faces the bench's bit driver, which miscounts clocks on purpose.
   sbw_eeprom_dev #(.PROG_CYCLES(PC)) sbw_eeprom_dev_i2 (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .low_supply_i(low_supply), .peek_addr_i(peek_addr), .peek_data_o(peek_data[1]), .prog_en_o(prog_en[1]),
      .busy_o(busy[1]), .link(link2.device));
   sbw_link_props #(.PROG_CYCLES(PC)) sbw_link_props_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .low_supply_i(low_supply), .prog_en_o(prog_en[0]), .busy_o(busy[0]), .chip_sel(link.chip_sel),
      .serial_clk(link.serial_clk), .out_d(link.out_d), .out_oe_n(link.out_oe_n));

   initial begin
      sys_clk_i = 1'h0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      #(60000 * 25);
      n_errors++;
      test_done();
   end

   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic mdl(input int d, input sbw_pkg::sbw_cmd_type k, input logic [15:0] w);
      if (k == sbw_pkg::SBW_LOCK) men[d] = 0;
      if (k == sbw_pkg::SBW_UNLOCK) men[d] = 1;
      for (int a = 0; a < 2 ** AW; a++) begin
         if (men[d] == 1 && k == sbw_pkg::SBW_FILL) mm[d][a] = int'(w);
         if (men[d] == 1 && k == sbw_pkg::SBW_CLEAR) mm[d][a] = int'(sbw_pkg::CLEAR_WORD);
      end
   endtask : mdl

   task automatic chk_all(input int d);
      for (int a = 0; a < 2 ** AW; a++) begin
         @(negedge sys_clk_i);
         peek_addr = AW'(a);
         @(negedge sys_clk_i);
         chk("word", peek_data[d], 16'(mm[d][a]));
      end
      chk("prog_en", 16'(prog_en[d]), 16'(men[d]));
   endtask : chk_all

   task automatic cmd(input sbw_pkg::sbw_cmd_type k, input logic [15:0] w);
      int t;
      @(negedge sys_clk_i);
      chk("ready", 16'(ready), 16'h1);
      cmd_valid = 1'h1;
      cmd_kind = k;
      cmd_data = w;
      @(negedge sys_clk_i);
      cmd_valid = 1'h0;
      t = 0;
      while (done !== 1'h1 && t < 4000) begin
         @(negedge sys_clk_i);
         t++;
      end
      chk("done", 16'(done), 16'h1);
      mdl(0, k, w);
   endtask : cmd

   // Sends d dummy clocks, the start bit, then m clocks of opcode, address and data.
   task automatic frame(input sbw_pkg::sbw_cmd_type k, input logic [15:0] w, input int d, input int m);
      logic [31:0] v;
      logic [55:0] bits;
      logic [1:0] ext;
      int t;
      v = rnd();
      case (k)
         sbw_pkg::SBW_FILL: ext = sbw_pkg::EXT_FILL;
         sbw_pkg::SBW_CLEAR: ext = sbw_pkg::EXT_CLEAR;
         sbw_pkg::SBW_UNLOCK: ext = sbw_pkg::EXT_UNLOCK;
         default: ext = sbw_pkg::EXT_LOCK;
      endcase
      bits = {23'h0, sbw_pkg::START_BIT, sbw_pkg::OP_EXT, ext, v[3:0] | 4'h1, w, 8'h0};
      @(negedge sys_clk_i);
      link2.chip_sel = 1'h1;
      for (t = 0; t < d + 1 + m; t++) begin
         link2.serial_in = bits[32 + d - t];
         #3 link2.serial_clk = 1'h1;
         #3 link2.serial_clk = 1'h0;
      end
      link2.serial_in = ~link2.serial_in;
      link2.chip_sel = 1'h0;
      repeat (8) @(negedge sys_clk_i);
      t = 0;
      while (busy[1] !== 1'h0 && t < 400) begin
         @(negedge sys_clk_i);
         t++;
      end
      if (k == sbw_pkg::SBW_FILL ? m == AW + 18 : k == sbw_pkg::SBW_CLEAR ? m == AW + 2 : m >= 4 && m <= AW + 2)
         mdl(1, k, w);
   endtask : frame

   task automatic dip();
      @(negedge sys_clk_i);
      low_supply = 1'h1;
      repeat (6) @(negedge sys_clk_i);
      low_supply = 1'h0;
      men = '{0, 0};
      repeat (4) @(negedge sys_clk_i);
   endtask : dip

   task automatic test_done();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   initial begin
      logic [31:0] v;
      rs = 32'h54;
      reset_i = 1'h1;
      low_supply = 1'h0;
      cmd_valid = 1'h0;
      cmd_kind = sbw_pkg::SBW_LOCK;
      cmd_data = 16'h0;
      peek_addr = '0;
      link2.chip_sel = 1'h0;
      link2.serial_clk = 1'h0;
      link2.serial_in = 1'h0;
      men = '{0, 0};
      repeat (16) @(negedge sys_clk_i);
      reset_i = 1'h0;
      chk("prog_en", 16'(prog_en[0]), 16'h0);
      cmd(sbw_pkg::SBW_LOCK, 16'h0);
      cmd(sbw_pkg::SBW_UNLOCK, 16'h0);
      cmd(sbw_pkg::SBW_CLEAR, 16'h0);
      chk_all(0);
      repeat (2) begin
         v = rnd();
         cmd(sbw_pkg::SBW_FILL, v[15:0]);
         chk_all(0);
      end
      cmd(sbw_pkg::SBW_LOCK, 16'h0);
      chk_all(0);
      cmd(sbw_pkg::SBW_UNLOCK, 16'h0);
      dip();
      chk_all(0);
      cmd(sbw_pkg::SBW_UNLOCK, 16'h0);
      v = rnd();
      cmd(sbw_pkg::SBW_FILL, v[15:0]);
      chk_all(0);
      frame(sbw_pkg::SBW_UNLOCK, 16'h0, 3, 8);
      v = rnd();
      frame(sbw_pkg::SBW_FILL, v[15:0], 2, 24);
      chk_all(1);
      frame(sbw_pkg::SBW_FILL, ~v[15:0], 0, 25);
      frame(sbw_pkg::SBW_FILL, ~v[15:0], 0, 23);
      frame(sbw_pkg::SBW_CLEAR, 16'h0, 0, 9);
      frame(sbw_pkg::SBW_CLEAR, 16'h0, 0, 7);
      chk_all(1);
      frame(sbw_pkg::SBW_CLEAR, 16'h0, 1, 8);
      chk_all(1);
      frame(sbw_pkg::SBW_LOCK, 16'h0, 0, 8);
      frame(sbw_pkg::SBW_FILL, v[15:0], 0, 24);
      chk_all(1);
      frame(sbw_pkg::SBW_UNLOCK, 16'h0, 0, 4);
      chk("prog_en", 16'(prog_en[1]), 16'h1);
      dip();
      frame(sbw_pkg::SBW_FILL, v[15:0], 0, 24);
      chk_all(1);
      test_done();
   end
endmodule : serial_eeprom_bulk_write_guard_bench
